// *** verilog/sdpb_pkg.sv ***
// Constants for the failure-prediction data page builder
package sdpb_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_FEATURE  = 8'h00;
   localparam logic [7:0] ADDR_DATA     = 8'h04;
   localparam logic [7:0] ADDR_CYL      = 8'h08;
   localparam logic [7:0] ADDR_STATUS   = 8'h0C;
   localparam logic [7:0] ADDR_SLOT     = 8'h10;
   localparam logic [7:0] ADDR_SLOT_DEF = 8'h14;
   localparam logic [7:0] ADDR_SLOT_VAL = 8'h18;
   localparam logic [7:0] ADDR_RAW_LO   = 8'h1C;
   localparam logic [7:0] ADDR_RAW_HI   = 8'h20;
   localparam logic [7:0] ADDR_CAPS     = 8'h24;
   localparam logic [7:0] ADDR_INT_STAT = 8'h28;
   localparam logic [7:0] ADDR_INT_CLR  = 8'h2C;
   localparam logic [7:0] ADDR_INT_EN   = 8'h30;
   // ----------------------------------------
   // Subcommands and status keys
   // ----------------------------------------
   localparam logic [7:0] SUB_READ_VALS = 8'hD0;
   localparam logic [7:0] SUB_READ_THR  = 8'hD1;
   localparam logic [7:0] SUB_RET_STAT  = 8'hDA;
   localparam logic [7:0] KEY_LO_OK     = 8'h4F;
   localparam logic [7:0] KEY_HI_OK     = 8'hC2;
   localparam logic [7:0] KEY_LO_FAIL   = 8'hF4;
   localparam logic [7:0] KEY_HI_FAIL   = 8'h2C;
   // ----------------------------------------
   // Page layout
   // ----------------------------------------
   localparam logic [15:0] FMT_VERSION  = 16'h0001;
   localparam int          NUM_SLOTS    = 30;
   localparam logic [8:0]  IDX_VER_HI   = 9'h001;
   localparam logic [8:0]  IDX_REC_LO   = 9'h002;
   localparam logic [8:0]  IDX_REC_HI   = 9'h169;
   localparam logic [8:0]  IDX_CAPS_LO  = 9'h170;
   localparam logic [8:0]  IDX_CAPS_HI  = 9'h171;
   localparam logic [8:0]  IDX_CKSUM    = 9'h1FF;
   localparam logic [3:0]  OFF_ID       = 4'h0;
   localparam logic [3:0]  OFF_FLAG_LO  = 4'h1;
   localparam logic [3:0]  OFF_FLAG_HI  = 4'h2;
   localparam logic [3:0]  OFF_CUR      = 4'h3;
   localparam logic [3:0]  OFF_WORST    = 4'h4;
   localparam logic [3:0]  OFF_RAW0     = 4'h5;
   localparam logic [3:0]  OFF_RAW5     = 4'hA;
   localparam logic [3:0]  OFF_LAST     = 4'hB;
   localparam logic [3:0]  OFF_THR      = 4'h1;
   localparam logic [7:0]  VAL_MIN      = 8'h01;
   localparam logic [7:0]  VAL_MAX      = 8'h64;
   // ----------------------------------------
   // Interrupt bits
   // ----------------------------------------
   localparam int INT_READY = 0;
   localparam int INT_DONE  = 1;
   localparam int INT_FAIL  = 2;
   localparam int INT_W     = 3;

   typedef enum logic [1:0] {
      SDPB_IDLE = 2'b00,
      SDPB_SEND = 2'b01,
      SDPB_STAT = 2'b11
   } sdpb_state_t;

   function automatic logic [7:0] sdpbClamp(input logic [7:0] v);
      return (v < VAL_MIN) ? VAL_MIN : ((v > VAL_MAX) ? VAL_MAX : v);
   endfunction
endpackage

// *** verilog/sdpb_csum.sv ***
// Running byte sum of a page being sent
`timescale 1ns/1ps
module sdpb_csum
   import sdpb_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       clear,
   input  wire logic       add,
   input  wire logic [7:0] dataByte,
   output logic      [7:0] sum
);
   // ----------------------------------------
   // Accumulator
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sum <= 8'h00;
      end else if (clear) begin
         sum <= 8'h00;
      end else if (add) begin
         sum <= sum + dataByte;
      end
   end
endmodule

// *** verilog/sdpb_builder.sv ***
// Failure-prediction data page builder with register port
// Notes on behaviour
// [RL1] Value page is exactly 512 bytes
// [RL2] Threshold page is exactly 512 bytes
// [RL3] Record: id, flags, current, worst, raw, reserved
// [RL4] Value page: version, records, caps, vendor
// [RL5] Threshold page: id, threshold, ten reserved
// [RL6] Same version number in both pages
// [RL7] Identifier zero marks an unused record
// [RL8] Flag bit 0 only; bits 1-15 reserved
// [RL9] Current value clamped to 01h..64h
// [RL10] Normal only when value exceeds threshold
// [RL11] Worst value follows lowest value seen
// [RL12] Raw bytes keep the unnormalized data
// [RL13] Capability bits 0 and 1; rest reserved
// [RL14] Last byte makes page sum zero
// [RL15] Host compares values against thresholds
// [RL16] Status return loads cylinder key bytes
// [RL17] Reserved and vendor bytes read zero
`timescale 1ns/1ps
module sdpb_builder
   import sdpb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdData,
   output logic             irq
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   sdpb_state_t       state;
   logic              page;
   logic [8:0]        byteIdx;
   logic [4:0]        recSlot;
   logic [3:0]        recOff;
   logic [7:0]        featureSelectReg;
   logic [7:0]        cylinderLowReg;
   logic [7:0]        cylinderHighReg;
   logic [4:0]        slotSel;
   logic [1:0]        capFlags;
   logic [INT_W-1:0]  intStat;
   logic [INT_W-1:0]  intEn;
   logic [7:0]        attrId  [NUM_SLOTS];
   logic              attrFlg [NUM_SLOTS];
   logic [7:0]        attrCur [NUM_SLOTS];
   logic [7:0]        attrWst [NUM_SLOTS];
   logic [47:0]       attrRaw [NUM_SLOTS];
   logic [7:0]        attrThr [NUM_SLOTS];
   logic [7:0]        sum;
   logic              anyFail;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire        sending   = (state == SDPB_SEND);
   wire        wrFeature = regWr && (regAddr == ADDR_FEATURE);
   wire        startVals = wrFeature && (state == SDPB_IDLE) && (regWrData[7:0] == SUB_READ_VALS);
   wire        startThr  = wrFeature && (state == SDPB_IDLE) && (regWrData[7:0] == SUB_READ_THR);
   wire        startStat = wrFeature && (state == SDPB_IDLE) && (regWrData[7:0] == SUB_RET_STAT);
   wire        dataRd    = regRd && (regAddr == ADDR_DATA) && sending;
   wire        lastByte  = (byteIdx == IDX_CKSUM);
   wire        wrDef     = regWr && (regAddr == ADDR_SLOT_DEF) && (slotSel < 5'(NUM_SLOTS));
   wire        wrVal     = regWr && (regAddr == ADDR_SLOT_VAL) && (slotSel < 5'(NUM_SLOTS));
   wire        wrRawLo   = regWr && (regAddr == ADDR_RAW_LO) && (slotSel < 5'(NUM_SLOTS));
   wire        wrRawHi   = regWr && (regAddr == ADDR_RAW_HI) && (slotSel < 5'(NUM_SLOTS));
   wire [7:0]  newCur    = sdpbClamp(regWrData[7:0]);

   // ----------------------------------------
   // Page byte generation
   // ----------------------------------------
   wire        inRec     = (byteIdx >= IDX_REC_LO) && (byteIdx <= IDX_REC_HI);
   wire [4:0]  slotRd    = inRec ? recSlot : 5'h00;
   wire        slotUsed  = (attrId[slotRd] != 8'h00);
   wire [3:0]  rawOff    = recOff - OFF_RAW0;
   wire [47:0] slotRaw   = attrRaw[slotRd];
   wire [7:0]  rawByte   = slotRaw[rawOff[2:0]*8 +: 8];
   wire [7:0]  valRecByte =
      (recOff == OFF_ID)      ? attrId[slotRd] :                       // RL3
      (recOff == OFF_FLAG_LO) ? {7'h00, attrFlg[slotRd]} :             // RL8
      (recOff == OFF_CUR)     ? attrCur[slotRd] :                      // RL3
      (recOff == OFF_WORST)   ? attrWst[slotRd] :                      // RL11
      ((recOff >= OFF_RAW0) && (recOff <= OFF_RAW5)) ? rawByte : 8'h00; // RL12
   wire [7:0]  thrRecByte =
      (recOff == OFF_ID)  ? attrId[slotRd] :                           // RL5
      (recOff == OFF_THR) ? attrThr[slotRd] : 8'h00;                   // RL5
   wire [7:0]  recByte   = !slotUsed ? 8'h00 : (page ? thrRecByte : valRecByte); // RL7
   wire [7:0]  cksumByte = 8'h00 - sum;                                // RL14
   wire [7:0]  pageByte  =
      (byteIdx == 9'h000)     ? FMT_VERSION[7:0] :                     // RL6
      (byteIdx == IDX_VER_HI) ? FMT_VERSION[15:8] :                    // RL6
      inRec                   ? recByte :                              // RL4
      lastByte                ? cksumByte :                            // RL14
      (!page && byteIdx == IDX_CAPS_LO) ? {6'h00, capFlags} :          // RL13
      8'h00;                                                           // RL17

   sdpb_csum u_csum (
      .clk      (clk),
      .rst      (rst),
      .clear    (startVals || startThr),
      .add      (dataRd),
      .dataByte (pageByte),
      .sum      (sum)
   );

   // ----------------------------------------
   // Failure comparison
   // ----------------------------------------
   always_comb begin
      anyFail = 1'b0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
         if (attrId[i] != 8'h00 && !(attrCur[i] > attrThr[i])) begin   // RL10
            anyFail = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state   <= SDPB_IDLE;
         page    <= 1'b0;
         byteIdx <= 9'h000;
         recSlot <= 5'h00;
         recOff  <= 4'h0;
      end else begin
         case (state)
            SDPB_IDLE: begin
               if (startVals || startThr) begin                        // RL1 RL2
                  state   <= SDPB_SEND;
                  page    <= startThr;
                  byteIdx <= 9'h000;
                  recSlot <= 5'h00;
                  recOff  <= 4'h0;
               end else if (startStat) begin
                  state <= SDPB_STAT;
               end
            end
            SDPB_SEND: begin
               if (dataRd) begin
                  byteIdx <= byteIdx + 9'h001;
                  if (lastByte) begin                                  // RL1 RL2
                     state <= SDPB_IDLE;
                  end
                  if (inRec) begin
                     recOff  <= (recOff == OFF_LAST) ? 4'h0 : recOff + 4'h1;
                     recSlot <= (recOff == OFF_LAST) ? recSlot + 5'h01 : recSlot;
                  end
               end
            end
            SDPB_STAT: begin
               state <= SDPB_IDLE;
            end
            default: begin
               state <= SDPB_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Task-file style registers
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         featureSelectReg <= 8'h00;
         cylinderLowReg   <= 8'h00;
         cylinderHighReg  <= 8'h00;
         slotSel          <= 5'h00;
         capFlags         <= 2'b00;
         intEn            <= '0;
      end else begin
         if (wrFeature) begin
            featureSelectReg <= regWrData[7:0];
         end
         if (state == SDPB_STAT) begin                                 // RL16
            cylinderLowReg  <= anyFail ? KEY_LO_FAIL : KEY_LO_OK;
            cylinderHighReg <= anyFail ? KEY_HI_FAIL : KEY_HI_OK;
         end
         if (regWr && regAddr == ADDR_SLOT) begin
            slotSel <= regWrData[4:0];
         end
         if (regWr && regAddr == ADDR_CAPS) begin
            capFlags <= regWrData[1:0];                                // RL13
         end
         if (regWr && regAddr == ADDR_INT_EN) begin
            intEn <= regWrData[INT_W-1:0];
         end
      end
   end

   // ----------------------------------------
   // Attribute table
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            attrId[i]  <= 8'h00;
            attrFlg[i] <= 1'b0;
            attrCur[i] <= VAL_MAX;
            attrWst[i] <= VAL_MAX;
            attrRaw[i] <= 48'h0;
            attrThr[i] <= 8'h00;
         end
      end else begin
         if (wrDef) begin
            attrId[slotSel]  <= regWrData[7:0];                        // RL7
            attrFlg[slotSel] <= regWrData[8];                          // RL8
            attrThr[slotSel] <= regWrData[23:16];
            attrCur[slotSel] <= VAL_MAX;
            attrWst[slotSel] <= VAL_MAX;
         end else if (wrVal) begin
            attrCur[slotSel] <= newCur;                                // RL9
            if (newCur < attrWst[slotSel]) begin                       // RL11
               attrWst[slotSel] <= newCur;
            end
         end
         if (wrRawLo) begin
            attrRaw[slotSel][31:0] <= regWrData;                       // RL12
         end
         if (wrRawHi) begin
            attrRaw[slotSel][47:32] <= regWrData[15:0];                // RL12
         end
      end
   end

   // ----------------------------------------
   // Interrupts and read port
   // ----------------------------------------
   wire [INT_W-1:0] intEvent = {state == SDPB_STAT && anyFail,
                                dataRd && lastByte,
                                startVals || startThr};
   wire [INT_W-1:0] intClr   = (regWr && regAddr == ADDR_INT_CLR) ? regWrData[INT_W-1:0] : '0;
   wire [31:0] next_rdData   =
      (regAddr == ADDR_FEATURE)  ? {24'h0, featureSelectReg} :
      (regAddr == ADDR_DATA)     ? {24'h0, sending ? pageByte : 8'h00} :
      (regAddr == ADDR_CYL)      ? {16'h0, cylinderHighReg, cylinderLowReg} :
      (regAddr == ADDR_STATUS)   ? {16'h0, 3'h0, byteIdx, 1'b0, anyFail, page, sending} :
      (regAddr == ADDR_SLOT)     ? {27'h0, slotSel} :
      (regAddr == ADDR_CAPS)     ? {30'h0, capFlags} :
      (regAddr == ADDR_INT_STAT) ? {29'h0, intStat} :
      (regAddr == ADDR_INT_EN)   ? {29'h0, intEn} : 32'h0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         intStat   <= '0;
         irq       <= 1'b0;
         regRdData <= 32'h0;
      end else begin
         intStat   <= (intStat & ~intClr) | intEvent;
         irq       <= |(((intStat & ~intClr) | intEvent) & intEn);
         regRdData <= regRd ? next_rdData : 32'h0;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_VALS_LEN: assert property (dataRd && !page && lastByte |=> state == SDPB_IDLE) // RL1
      else $error("value page did not end at byte 511");
   AST_THR_START: assert property (startThr |=> sending && page && byteIdx == 9'h000) // RL2
      else $error("threshold page did not start");
   AST_REC_CUR: assert property (dataRd && inRec && slotUsed && !page && recOff == OFF_CUR
      |=> regRdData[7:0] == $past(attrCur[slotRd])) // RL3
      else $error("current value misplaced");
   AST_CAPS: assert property (dataRd && !page && byteIdx == IDX_CAPS_LO
      |=> regRdData == {30'h0, $past(capFlags)}) // RL4
      else $error("capability byte wrong");
   AST_THR_BYTE: assert property (dataRd && inRec && slotUsed && page && recOff == OFF_THR
      |=> regRdData[7:0] == $past(attrThr[slotRd])) // RL5
      else $error("threshold byte wrong");
   AST_VERSION: assert property (dataRd && byteIdx == 9'h000
      |=> regRdData[7:0] == FMT_VERSION[7:0]) // RL6
      else $error("version byte wrong");
   AST_UNUSED: assert property (dataRd && inRec && !slotUsed |=> regRdData == 32'h0) // RL7
      else $error("unused record not zero");
   AST_FLAG_HI: assert property (dataRd && inRec && recOff == OFF_FLAG_HI |=> regRdData == 32'h0) // RL8
      else $error("reserved flag bits set");
   AST_CLAMP: assert property (wrVal ##1 1'b1 |-> attrCur[$past(slotSel)] >= VAL_MIN
      && attrCur[$past(slotSel)] <= VAL_MAX) // RL9
      else $error("current value out of range");
   AST_NORMAL: assert property (state == SDPB_STAT && !anyFail
      |=> cylinderLowReg == KEY_LO_OK && cylinderHighReg == KEY_HI_OK) // RL10
      else $error("normal status keys wrong");
   AST_WORST: assert property (wrVal && newCur < attrWst[slotSel]
      |=> attrWst[$past(slotSel)] == $past(newCur)) // RL11
      else $error("worst value not updated");
   AST_RAW: assert property (wrRawLo |=> attrRaw[$past(slotSel)][31:0] == $past(regWrData)) // RL12
      else $error("raw data not kept");
   AST_CAPS_HI: assert property (dataRd && !page && byteIdx == IDX_CAPS_HI |=> regRdData == 32'h0) // RL13
      else $error("reserved capability bits set");
   AST_CKSUM: assert property (dataRd && lastByte
      |=> 8'(regRdData[7:0] + $past(sum)) == 8'h00) // RL14
      else $error("checksum does not zero the page");
   AST_FAIL_KEYS: assert property (state == SDPB_STAT && anyFail
      |=> cylinderLowReg == KEY_LO_FAIL && cylinderHighReg == KEY_HI_FAIL) // RL16
      else $error("failure status keys wrong");
   AST_VENDOR: assert property (dataRd && byteIdx > IDX_CAPS_HI && !lastByte |=> regRdData == 32'h0) // RL17
      else $error("vendor area not zero");
endmodule

// *** tb/sdpb_host_model.sv ***
// Host-side model that drives the register port and fetches data pages
`timescale 1ns/1ps
module sdpb_host_model
   import sdpb_pkg::*;
(
   input  wire logic        clk,
   output logic      [7:0]  regAddr,
   output logic      [31:0] regWrData,
   output logic             regWr,
   output logic             regRd,
   input  wire logic [31:0] regRdData
);
   logic [7:0] page [2][512];

   initial begin
      regAddr   = 8'h00;
      regWrData = 32'h0000_0000;
      regWr     = 1'b0;
      regRd     = 1'b0;
   end

   // ----------------------------------------
   // Single-cycle bus strobes
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr   <= a;
      regWrData <= d;
      regWr     <= 1'b1;
      @(posedge clk);
      regWr     <= 1'b0;
      regAddr   <= ~a;
      regWrData <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd   <= 1'b0;
      regAddr <= ~a;
      @(negedge clk);
      d = regRdData;
   endtask

   // ----------------------------------------
   // Page fetch and failure prediction
   // ----------------------------------------
   task automatic readPage(input logic [7:0] sub);
      logic [31:0] d;
      int          p;
      p = (sub == SUB_READ_THR) ? 1 : 0;
      wr(ADDR_FEATURE, {24'h000000, sub});
      for (int i = 0; i < 512; i++) begin
         if (i == 256) begin
            wr(ADDR_FEATURE, {24'h000000, sub ^ 8'h01});
         end
         rd(ADDR_DATA, d);
         page[p][i] = d[7:0];
      end
   endtask

   function automatic logic predictFail();
      logic f;
      f = 1'b0;
      for (int s = 0; s < 30; s++) begin
         for (int t = 0; t < 30; t++) begin
            if (page[0][2+12*s] != 8'h00 && page[1][2+12*t] == page[0][2+12*s] &&
                page[0][5+12*s] <= page[1][3+12*t]) begin
               f = 1'b1;
            end
         end
      end
      return f;
   endfunction
endmodule

// *** tb/smart_data_page_builder_test.sv ***
// Self-checking testbench for the data page builder
`timescale 1ns/1ps
module smart_data_page_builder_test
   import sdpb_pkg::*;
;
   logic        clk;
   logic        rst;
   logic [7:0]  regAddr;
   logic [31:0] regWrData;
   logic        regWr;
   logic        regRd;
   logic [31:0] regRdData;
   logic        irq;
   int          bad_count;
   int          samples_checked;
   logic [7:0]  sid [30];
   logic        sflg [30];
   logic [7:0]  scur [30];
   logic [7:0]  swst [30];
   logic [7:0]  sthr [30];
   logic [47:0] sraw [30];
   logic [7:0]  want [512];
   logic [31:0] d;
   logic [7:0]  ids [9] = '{8'd3, 8'd4, 8'd5, 8'd9, 8'd10, 8'd12, 8'd200, 8'd201, 8'd255};

   sdpb_builder dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
                     .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq));
   sdpb_host_model host (.clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
                         .regRd(regRd), .regRdData(regRdData));

   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", what, e, g);
         bad_count++;
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic defSlot(input int s, input logic [7:0] id, input logic f, input logic [7:0] t);
      host.wr(ADDR_SLOT, s);
      host.wr(ADDR_SLOT_DEF, {8'h00, t, 7'h00, f, id});
      sid[s] = id;
      sflg[s] = f;
      sthr[s] = t;
      scur[s] = 8'h64;
      swst[s] = 8'h64;
   endtask

   task automatic setVal(input int s, input logic [7:0] v);
      host.wr(ADDR_SLOT, s);
      host.wr(ADDR_SLOT_VAL, {24'h000000, v});
      scur[s] = (v < 8'h01) ? 8'h01 : ((v > 8'h64) ? 8'h64 : v);
      if (scur[s] < swst[s]) swst[s] = scur[s];
   endtask

   task automatic setRaw(input int s, input logic [47:0] r);
      host.wr(ADDR_SLOT, s);
      host.wr(ADDR_RAW_LO, r[31:0]);
      host.wr(ADDR_RAW_HI, {16'h0000, r[47:32]});
      sraw[s] = r;
   endtask

   task automatic checkPage(input int p, input logic [1:0] caps);
      logic [7:0] sum;
      int         b;
      sum = 8'h00;
      for (int i = 0; i < 512; i++) want[i] = 8'h00;
      want[0] = FMT_VERSION[7:0];
      want[1] = FMT_VERSION[15:8];
      for (int s = 0; s < 30; s++) begin
         b = 2 + 12 * s;
         if (sid[s] != 8'h00) begin
            want[b] = sid[s];
            want[b+1] = (p == 0) ? {7'h00, sflg[s]} : sthr[s];
            if (p == 0) begin
               want[b+3] = scur[s];
               want[b+4] = swst[s];
               for (int k = 0; k < 6; k++) want[b+5+k] = sraw[s][8*k +: 8];
            end
         end
      end
      if (p == 0) want[9'h170] = {6'h00, caps};
      for (int i = 0; i < 511; i++) sum = sum + want[i];
      want[511] = 8'h00 - sum;
      host.readPage((p == 0) ? SUB_READ_VALS : SUB_READ_THR);
      sum = 8'h00;
      for (int i = 0; i < 512; i++) begin
         chk($sformatf("page%0d byte %h", p, i), want[i], host.page[p][i]);
         sum = sum + host.page[p][i];
      end
      chk("page sum", 32'h0, sum);
      host.rd(ADDR_STATUS, d);
      chk("sending after 512", 32'h0, d[0]);
      host.rd(ADDR_DATA, d);
      chk("data after page", 32'h0, d);
   endtask

   task automatic status(input logic fail);
      host.wr(ADDR_FEATURE, {24'h000000, SUB_RET_STAT});
      host.rd(ADDR_CYL, d);
      chk("cylinder keys", fail ? {16'h0, KEY_HI_FAIL, KEY_LO_FAIL} :
                                  {16'h0, KEY_HI_OK, KEY_LO_OK}, d);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      bad_count = 0;
      samples_checked = 0;
      for (int s = 0; s < 30; s++) begin
         sid[s] = 8'h00;
         sflg[s] = 1'b0;
         sthr[s] = 8'h00;
         scur[s] = 8'h64;
         swst[s] = 8'h64;
         sraw[s] = 48'h0;
      end
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      host.rd(ADDR_CAPS, d);
      chk("caps reset", 32'h0, d);
      host.rd(ADDR_CYL, d);
      chk("cylinder reset", 32'h0, d);
      host.rd(8'hFC, d);
      chk("unmapped read", 32'h0, d);
      chk("irq reset", 32'h0, irq);
      defSlot(0, 8'd5, 1'b1, 8'h20);
      setRaw(0, 48'hA1B2_C3D4_E5F6);
      setVal(0, 8'h30);
      setVal(0, 8'h10);
      setVal(0, 8'h40);
      defSlot(1, 8'd9, 1'b0, 8'h10);
      setVal(1, 8'h00);
      defSlot(29, 8'd200, 1'b1, 8'h00);
      setVal(29, 8'h80);
      for (int k = 0; k < 9; k++) defSlot(2 + k, ids[k], k[0], 8'h05);
      host.wr(ADDR_CAPS, 32'h3);
      checkPage(0, 2'h3);
      host.rd(ADDR_INT_STAT, d);
      chk("events after page", 32'h3, d);
      chk("irq masked", 32'h0, irq);
      checkPage(1, 2'h3);
      chk("host prediction", 32'h1, host.predictFail());
      host.wr(ADDR_INT_EN, 32'h2);
      host.rd(ADDR_INT_EN, d);
      chk("irq enabled", 32'h1, irq);
      host.wr(ADDR_INT_CLR, 32'h7);
      host.rd(ADDR_INT_STAT, d);
      chk("events cleared", 32'h0, d);
      chk("irq cleared", 32'h0, irq);
      host.wr(ADDR_INT_EN, 32'h4);
      status(1'b1);
      chk("irq on fail", 32'h1, irq);
      setVal(1, 8'h10);
      status(1'b1);
      setVal(1, 8'h11);
      status(1'b0);
      complete_run();
   end
endmodule
